//--- hw/spims_core.sv
// Summary of operation
// - Master drives clock with programmed rate, polarity
// - Master and enable drop when select low
// - Master bit ignored before status register write
// - Master data write starts byte, MSB first
// - Byte end sets done flag, raises irq
// - Master flag clear: status access, data read
// - Data writes load or start nothing while done flag is set
// - Slave takes clock from pin only
// - Slave data write loads shift, MSB first
// - Slave shifts only on external clock edges
// - Slave flag clear: status access, data access
// - Unwritten slave echoes previously received byte
// - Master bit and mode fault flag provided
module spims_core
   import spims_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_sck_clk,
   input wire logic i_ctrl_wr,
   input wire logic [7:0] i_ctrl_data,
   input wire logic i_cs_wr,
   input wire logic [1:0] i_cs_data,
   input wire logic i_cs_rd,
   input wire logic i_data_wr,
   input wire logic [7:0] i_data_in,
   input wire logic i_data_rd,
   input wire logic i_cpu_irq_mask,
   input wire logic i_sel_n,
   input wire logic i_mosi,
   input wire logic i_miso,
   output logic [7:0] o_serial_ctrl_reg,
   output logic o_xfer_done_flag,
   output logic o_mode_fault_flag,
   output logic o_busy,
   output logic [7:0] o_serial_data_reg,
   output logic o_irq,
   output logic o_sck,
   output logic o_sck_oe,
   output logic o_mosi,
   output logic o_mosi_oe,
   output logic o_miso,
   output logic o_miso_oe
);
   logic [7:0] ctrl_q;
   logic [1:0] cs_q;
   logic cs_written_q;
   logic done_q;
   logic fault_q;
   logic armed_q;
   logic [7:0] rx_q;
   logic [7:0] tx_q;
   logic [7:0] shift_q;
   logic [3:0] cnt_q;
   logic [7:0] div_q;
   logic sck_q;
   logic irq_q;
   logic sel_sync;
   logic sel_int;
   logic master_on;
   logic slave_on;
   logic [7:0] div_limit;
   logic tick;
   logic m_done;
   logic [7:0] m_rx;
   logic data_wr_ok;
   logic clr_hit;
   spims_state_type state_q;
   logic [7:0] s_shift_q;
   logic [7:0] s_rx_q;
   logic [2:0] s_cnt_q;
   logic [2:0] s_cnt_m_q;
   logic [2:0] s_cnt_s_q;
   logic s_tgl_q;
   logic s_act;
   logic [7:0] s_rx_word;
   logic s_tgl_sync;
   logic s_tgl_seen_q;
   logic s_done_evt;
   logic [7:0] s_cap_q;
   logic s_sel_n_clk;

   spims_sync u_sel_sync (
      .i_clk(i_clk),
      .i_d(i_sel_n),
      .o_q(sel_sync)
   );

   // Effective select: software level or synchronised pin
   assign sel_int = cs_q[CS_SEL_MANAGE] ? cs_q[CS_SEL_LEVEL] : sel_sync;
   assign master_on = ctrl_q[CR_ENABLE] & ctrl_q[CR_MASTER];
   assign slave_on = ctrl_q[CR_ENABLE] & ~ctrl_q[CR_MASTER];
   assign div_limit = 8'((DIV_BASE << ctrl_q[CR_RATE_LO +: 3]) - DIV_ONE);
   assign tick = (div_q == div_limit);
   assign data_wr_ok = i_data_wr & ~done_q;
   // Flag clear requires prior status access while set
   assign clr_hit = armed_q & (i_data_rd | (slave_on & i_data_wr));

   // Control register with mode fault handling
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         ctrl_q <= CR_RESET;
         fault_q <= 1'b0;
      end else begin
         if (i_ctrl_wr) begin
            ctrl_q <= i_ctrl_data;
            if (!cs_written_q) begin
               ctrl_q[CR_MASTER] <= 1'b0;
            end
         end else if (ctrl_q[CR_MASTER] && !sel_int) begin
            ctrl_q[CR_MASTER] <= 1'b0;
            ctrl_q[CR_ENABLE] <= 1'b0;
            fault_q <= 1'b1;
         end else if (i_cs_rd && fault_q && i_ctrl_wr) begin
            fault_q <= 1'b0;
         end
         if (fault_q && i_cs_rd && !(ctrl_q[CR_MASTER] && !sel_int)) begin
            fault_q <= 1'b0;
         end
      end
   end

   // Control/status register
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         cs_q <= CS_RESET;
         cs_written_q <= 1'b0;
      end else if (i_cs_wr) begin
         cs_q <= i_cs_data;
         cs_written_q <= 1'b1;
      end
   end

   // Done flag, set wins over clear
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         done_q <= 1'b0;
         armed_q <= 1'b0;
      end else begin
         if ((i_cs_rd || i_cs_wr) && done_q) begin
            armed_q <= 1'b1;
         end else if (clr_hit) begin
            armed_q <= 1'b0;
         end
         if ((master_on && m_done) || (slave_on && s_done_evt)) begin
            done_q <= 1'b1;
         end else if (clr_hit) begin
            done_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= done_q & ctrl_q[CR_IRQ_EN] & ~i_cpu_irq_mask;
      end
   end

   // Master divider and bit engine
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state_q <= SPIMS_IDLE;
         div_q <= DIV_ZERO;
         cnt_q <= CNT_ZERO;
         shift_q <= BYTE_RESET;
         sck_q <= 1'b0;
         m_done <= 1'b0;
         m_rx <= BYTE_RESET;
      end else begin
         m_done <= 1'b0;
         case (state_q)
            SPIMS_IDLE: begin
               sck_q <= ctrl_q[CR_POL];
               div_q <= DIV_ZERO;
               if (master_on && data_wr_ok) begin
                  shift_q <= i_data_in;
                  cnt_q <= BITS_PER_BYTE;
                  state_q <= SPIMS_LEAD;
               end
            end
            SPIMS_LEAD: begin
               div_q <= tick ? DIV_ZERO : 8'(div_q + DIV_ONE);
               if (!master_on) begin
                  state_q <= SPIMS_IDLE;
               end else if (tick) begin
                  sck_q <= ~sck_q;
                  if (!ctrl_q[CR_PHASE]) begin
                     m_rx <= {m_rx[6:0], i_miso};
                  end else begin
                     shift_q <= {shift_q[6:0], 1'b0};
                  end
                  state_q <= SPIMS_TRAIL;
               end
            end
            SPIMS_TRAIL: begin
               div_q <= tick ? DIV_ZERO : 8'(div_q + DIV_ONE);
               if (!master_on) begin
                  state_q <= SPIMS_IDLE;
               end else if (tick) begin
                  sck_q <= ~sck_q;
                  if (ctrl_q[CR_PHASE]) begin
                     m_rx <= {m_rx[6:0], i_miso};
                  end else begin
                     shift_q <= {shift_q[6:0], 1'b0};
                  end
                  cnt_q <= 4'(cnt_q - CNT_ONE);
                  if (cnt_q == CNT_ONE) begin
                     m_done <= 1'b1;
                     state_q <= SPIMS_IDLE;
                  end else begin
                     state_q <= SPIMS_LEAD;
                  end
               end
            end
            default: state_q <= SPIMS_IDLE;
         endcase
      end
   end

   // Master pin outputs
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_sck <= 1'b0;
         o_sck_oe <= 1'b0;
         o_mosi <= 1'b0;
         o_mosi_oe <= 1'b0;
      end else begin
         o_sck <= sck_q;
         o_sck_oe <= master_on;
         o_mosi <= shift_q[7];
         o_mosi_oe <= master_on;
      end
   end

   // Transmit byte for slave side
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         tx_q <= BYTE_RESET;
      end else if (slave_on && data_wr_ok) begin
         tx_q <= i_data_in;
      end else if (slave_on && s_done_evt) begin
         tx_q <= s_rx_word;
      end
   end

   // Link domain: slave shifter on the pin clock
   assign s_sel_n_clk = i_sel_n;
   // Shift on external clock while selected
   assign s_act = ~s_sel_n_clk;

   // Receive on pin clock, MSB first
   // Bit count and toggle start known; link clock may be silent at reset
   always_ff @(posedge i_sck_clk or posedge i_rst) begin
      if (i_rst) begin
         s_cnt_q <= 3'h0;
         s_tgl_q <= 1'b0;
      end else if (s_act) begin
         s_shift_q <= {s_shift_q[6:0], i_mosi};
         s_cnt_q <= 3'(s_cnt_q + 3'h1);
         if (s_cnt_q == 3'h7) begin
            s_rx_q <= {s_shift_q[6:0], i_mosi};
            s_tgl_q <= ~s_tgl_q;
         end
      end else begin
         s_cnt_q <= 3'h0;
      end
   end

   spims_sync u_tgl_sync (
      .i_clk(i_clk),
      .i_d(s_tgl_q),
      .o_q(s_tgl_sync)
   );

   // Byte-done event from toggle crossing
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         s_tgl_seen_q <= 1'b0;
         s_cap_q <= BYTE_RESET;
      end else begin
         s_tgl_seen_q <= s_tgl_sync;
         if (s_done_evt) begin
            s_cap_q <= s_rx_q;
         end
      end
   end
   assign s_done_evt = s_tgl_sync ^ s_tgl_seen_q;
   assign s_rx_word = s_rx_q;

   // MISO bit picked by the link bit count, brought over by two flops
   // The count moves once per link bit, far slower than this clock,
   // so the MSB stands before the first edge of every frame
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         s_cnt_m_q <= 3'h0;
         s_cnt_s_q <= 3'h0;
         o_miso <= 1'b0;
      end else begin
         s_cnt_m_q <= s_cnt_q;
         s_cnt_s_q <= s_cnt_m_q;
         o_miso <= tx_q[3'(3'h7 - s_cnt_s_q)];
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         rx_q <= BYTE_RESET;
      end else if (master_on && m_done) begin
         rx_q <= m_rx;
      end else if (s_done_evt) begin
         rx_q <= s_rx_q;
      end
   end

   // Status outputs
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_serial_ctrl_reg <= CR_RESET;
         o_xfer_done_flag <= 1'b0;
         o_mode_fault_flag <= 1'b0;
         o_busy <= 1'b0;
         o_serial_data_reg <= BYTE_RESET;
         o_irq <= 1'b0;
         o_miso_oe <= 1'b0;
      end else begin
         o_serial_ctrl_reg <= ctrl_q;
         o_xfer_done_flag <= done_q;
         o_mode_fault_flag <= fault_q;
         o_busy <= (state_q != SPIMS_IDLE);
         o_serial_data_reg <= rx_q;
         o_irq <= irq_q;
         o_miso_oe <= slave_on & ~sel_sync;
      end
   end
endmodule

//--- shared/spims_pkg.sv
package spims_pkg;
   // Control register field positions
   localparam int CR_RATE_LO = 0;
   localparam int CR_PHASE = 3;
   localparam int CR_POL = 4;
   localparam int CR_MASTER = 5;
   localparam int CR_ENABLE = 6;
   localparam int CR_IRQ_EN = 7;
   // Control/status write field positions
   localparam int CS_SEL_LEVEL = 0;
   localparam int CS_SEL_MANAGE = 1;
   // Reset values
   localparam logic [7:0] CR_RESET = 8'h00;
   localparam logic [1:0] CS_RESET = 2'h0;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   // Bits per byte and counter limits
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [7:0] DIV_BASE = 8'h02;
   localparam logic [7:0] DIV_ONE = 8'h01;
   localparam logic [7:0] DIV_ZERO = 8'h00;
   localparam logic [3:0] CNT_ZERO = 4'h0;
   localparam logic [3:0] CNT_ONE = 4'h1;

   typedef enum logic [1:0] {
      SPIMS_IDLE = 2'b00,
      SPIMS_LEAD = 2'b01,
      SPIMS_TRAIL = 2'b10
   } spims_state_type;
endpackage

//--- hw/spims_sync.sv
module spims_sync
   import spims_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_d,
   output logic o_q
);
   logic meta_q;
   // Two flip-flop level synchroniser
   always_ff @(posedge i_clk) begin
      meta_q <= i_d;
      o_q <= meta_q;
   end
endmodule

//--- verification/spims_core_chk.sv
module spims_core_chk
   import spims_pkg::*;
(
   input logic i_clk,
   input logic i_rst,
   input logic i_data_wr,
   input logic i_cs_rd,
   input logic i_cpu_irq_mask,
   input logic [7:0] o_serial_ctrl_reg,
   input logic o_xfer_done_flag,
   input logic o_mode_fault_flag,
   input logic o_busy,
   input logic o_irq,
   input logic o_sck,
   input logic o_sck_oe
);
   logic rd_q;
   logic sck_q;
   logic bsy_q;
   logic [4:0] edge_q;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // Status read seen while the flag is up
   always_ff @(posedge i_clk) begin
      if (i_rst || !o_xfer_done_flag) begin
         rd_q <= 1'h0;
      end else if (i_cs_rd) begin
         rd_q <= 1'h1;
      end
   end
   // Serial clock edges since the byte began
   always_ff @(posedge i_clk) begin
      sck_q <= o_sck;
      bsy_q <= o_busy;
      if (i_rst || (o_busy && !bsy_q)) begin
         edge_q <= 5'h00;
      end else if (o_sck != sck_q) begin
         edge_q <= edge_q + 5'h01;
      end
   end
   chk_irq_raise: assert property (
      (o_xfer_done_flag && o_serial_ctrl_reg[CR_IRQ_EN] && !i_cpu_irq_mask) [*2] |-> o_irq)
      else $error("irq missing");
   chk_irq_quiet: assert property (
      (!o_xfer_done_flag || i_cpu_irq_mask) [*2] |-> !o_irq) else $error("irq spurious");
   chk_wr_block: assert property (
      o_xfer_done_flag && !rd_q && !i_cs_rd && i_data_wr && !o_busy |=> ##1 !o_busy)
      else $error("write not blocked");
   chk_clear_order: assert property (
      $fell(o_xfer_done_flag) |-> $past(rd_q)) else $error("flag cleared early");
   chk_slave_nosck: assert property (
      !o_serial_ctrl_reg[CR_MASTER] [*2] |-> !o_sck_oe) else $error("slave drives clock");
   chk_fault_drop: assert property (
      $rose(o_mode_fault_flag) |-> ##[0:1] !o_serial_ctrl_reg[CR_MASTER]
      && !o_serial_ctrl_reg[CR_ENABLE]) else $error("fault kept master");
   chk_edge_count: assert property (
      $rose(o_xfer_done_flag) && o_serial_ctrl_reg[CR_MASTER] |-> ##[0:2] edge_q == 5'h10)
      else $error("edge count");
   chk_byte_done: assert property (
      $fell(o_busy) && o_serial_ctrl_reg[CR_MASTER] |-> ##[0:2] o_xfer_done_flag)
      else $error("flag not set");
endmodule

bind spims_core spims_core_chk i_spims_core_chk (.i_clk, .i_rst, .i_data_wr, .i_cs_rd,
   .i_cpu_irq_mask, .o_serial_ctrl_reg, .o_xfer_done_flag, .o_mode_fault_flag, .o_busy,
   .o_irq, .o_sck, .o_sck_oe);

//--- verification/spims_peer.sv
module spims_peer (
   input wire logic i_sck,
   input wire logic i_mosi,
   input wire logic i_miso,
   output logic o_miso,
   output logic o_lclk,
   output logic o_lmosi,
   output logic o_sel_n
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] tx_q;
   logic [7:0] rx_q;
   initial begin
      {tx_q, rx_q} = 16'h0000;
      {o_miso, o_lclk, o_lmosi, o_sel_n} = 4'h1;
   end
   // Slave side samples on rise, shifts on fall
   always @(posedge i_sck) rx_q = {rx_q[6:0], i_mosi};
   always @(negedge i_sck) begin
      tx_q = {tx_q[6:0], ~tx_q[0]};
      o_miso = tx_q[7];
   end
   task ld(input logic [7:0] b);
      tx_q = b;
      o_miso = b[7];
   endtask
   // select per byte
   // Master side clocks only inside the frame
   task xfer(input logic [7:0] b);
      o_sel_n = 1'h0;
      #100;
      for (int i = 7; i >= 0; i--) begin
         o_lmosi = b[i];
         #24 o_lclk = 1'h1;
         rx_q = {rx_q[6:0], i_miso};
         #24 o_lclk = 1'h0;
      end
      o_lmosi = ~o_lmosi;
      #24 o_sel_n = 1'h1;
   endtask
endmodule

//--- verification/spims_core_test.sv
module spims_core_test;
   import spims_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'h0;
   logic rst, cw, cs_w, cs_r, dw, dr, mask, flag, fault, busy, irq, sck, mosi, miso;
   logic pmiso, lclk, lmosi, sel_n;
   logic [1:0] csd;
   logic [7:0] cd, di, creg, rdat, b, p;
   int mismatches = 0;
   int cmp_count = 0;
   int t;
   integer seed;
   spims_core i_spims_core (.i_clk(clk), .i_rst(rst), .i_sck_clk(lclk), .i_ctrl_wr(cw),
      .i_ctrl_data(cd), .i_cs_wr(cs_w), .i_cs_data(csd), .i_cs_rd(cs_r), .i_data_wr(dw),
      .i_data_in(di), .i_data_rd(dr), .i_cpu_irq_mask(mask), .i_sel_n(sel_n), .i_mosi(lmosi),
      .i_miso(pmiso), .o_serial_ctrl_reg(creg), .o_xfer_done_flag(flag),
      .o_mode_fault_flag(fault), .o_busy(busy), .o_serial_data_reg(rdat), .o_irq(irq),
      .o_sck(sck), .o_sck_oe(), .o_mosi(mosi), .o_mosi_oe(), .o_miso(miso), .o_miso_oe());
   spims_peer i_spims_peer (.i_sck(sck), .i_mosi(mosi), .i_miso(miso), .o_miso(pmiso),
      .o_lclk(lclk), .o_lmosi(lmosi), .o_sel_n(sel_n));
   always #2.5 clk = ~clk;
   // Master setup: irq enable from bit 0, idle low clock
   function automatic logic [7:0] mcfg(input logic [2:0] r);
      return {r[0], 4'hc, r};
   endfunction
   task chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask
   // One strobe: 0 ctrl, 1 status write, 2 data write, 3 status read, 4 data read
   task wr(input int k, input logic [7:0] d);
      @(posedge clk);
      {cw, cs_w, dw, cs_r, dr} <= {k == 0, k == 1, k == 2, k == 3, k == 4};
      {cd, di, csd} <= {d, d, d[1:0]};
      @(posedge clk);
      {cw, cs_w, dw, cs_r, dr} <= 5'h00;
      repeat (2) @(negedge clk);
   endtask
   task wflag;
      int n;
      n = 0;
      while (flag !== 1'h1 && n < 9000) begin
         @(negedge clk);
         n++;
      end
      repeat (2) @(negedge clk);
      chk({7'h00, flag}, 8'h01);
   endtask
   task test_done;
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      #200000;
      mismatches++;
      test_done;
   end
   initial begin
      seed = 32'hffeff370;
      {rst, cw, cs_w, cs_r, dw, dr, mask} = 7'h40;
      {cd, di, csd} = 18'h00000;
      repeat (5) @(posedge clk);
      rst <= 1'h0;
      @(posedge clk);
      wr(0, 8'h60);
      chk(creg & 8'h20, 8'h00);
      for (t = 0; t < 8; t++) begin
         wr(1, 8'h03);
         wr(0, mcfg(t[2:0]));
         mask <= t[1];
         b = $random(seed);
         p = $random(seed);
         i_spims_peer.ld(p);
         wr(2, b);
         wflag;
         chk(i_spims_peer.rx_q, b);
         chk(rdat, p);
         chk({7'h00, irq}, {7'h00, t[0] & ~t[1]});
         wr(2, ~b);
         chk({7'h00, busy}, 8'h00);
         wr(4, 8'h00);
         wr(3, 8'h00);
         chk({7'h00, flag}, 8'h01);
         wr(4, 8'h00);
         chk({7'h00, flag}, 8'h00);
         $display("master rate %0d done", t);
      end
      wr(1, 8'h00);
      i_spims_peer.o_sel_n <= 1'h0;
      repeat (10) @(negedge clk);
      chk(creg & 8'h60, 8'h00);
      chk({7'h00, fault}, 8'h01);
      i_spims_peer.o_sel_n <= 1'h1;
      wr(3, 8'h00);
      chk({7'h00, fault}, 8'h00);
      $display("mode fault done");
      wr(0, 8'h40);
      b = $random(seed);
      p = $random(seed);
      wr(2, b);
      #7 i_spims_peer.xfer(p);
      wflag;
      chk(i_spims_peer.rx_q, b);
      chk(rdat, p);
      wr(3, 8'h00);
      wr(4, 8'h00);
      i_spims_peer.xfer(~p);
      wflag;
      chk(i_spims_peer.rx_q, p);
      wr(3, 8'h00);
      wr(2, b);
      chk({7'h00, flag}, 8'h00);
      $display("slave done");
      test_done;
   end
endmodule
